// ### rtl/tmoc_cfg.svh
// Constants for the timer output and counter-clear control block.
// Assumes byte-wide registers on a plain strobe port with a 3-bit address.
`ifndef TMOC_CFG_SVH
`define TMOC_CFG_SVH

// Register offsets
`define TMOC_ADDR_W        3
`define TMOC_OFS_CTRL0     3'h0
`define TMOC_OFS_CTRL1     3'h1
`define TMOC_OFS_CNT_LO    3'h2
`define TMOC_OFS_CNT_HI    3'h3
`define TMOC_OFS_CMPA_LO   3'h4
`define TMOC_OFS_CMPA_HI   3'h5

// Widths
`define TMOC_CNT_W         10
`define TMOC_COMPARE_P_VALUE_W        3
`define TMOC_DATA_W        8
`define TMOC_PINS          2

// Fields of the run control register
`define TMOC_C0_PAUSE      7
`define TMOC_C0_EN         3
`define TMOC_C0_COMPARE_P_VALUE_HI    2
`define TMOC_C0_COMPARE_P_VALUE_LO    0

// Fields of timer_output_control
`define TMOC_C1_MODE_HI    7
`define TMOC_C1_MODE_LO    6
`define TMOC_C1_IO_HI      5
`define TMOC_C1_IO_LO      4
`define TMOC_C1_OC         3
`define TMOC_C1_POL        2
`define TMOC_C1_DPX        1
`define TMOC_C1_CCLR       0

// Reset values
`define TMOC_RST_BYTE      8'h00
`define TMOC_RST_CNT       10'h000
`define TMOC_CNT_ONE       10'h001
`define TMOC_LOW7_ZERO     7'h00

// Output-function codes
`define TMOC_IO_NONE       2'h0
`define TMOC_IO_LOW        2'h1
`define TMOC_IO_HIGH       2'h2
`define TMOC_IO_TOGGLE     2'h3

`endif

// ### rtl/tmoc_pkg.sv
// Types for the timer output and counter-clear control block.
// Assumes tmoc_cfg.svh sits on the include path.
`include "tmoc_cfg.svh"

package tmoc_pkg;

    // Operating mode field
    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } tmoc_mode_e;

    // One register access
    typedef struct packed {
        logic                      wr;
        logic                      rd;
        logic [`TMOC_ADDR_W-1:0]   addr;
        logic [`TMOC_DATA_W-1:0]   wdata;
    } tmoc_bus_req_s;

    // Whole state of the block
    typedef struct packed {
        logic [`TMOC_DATA_W-1:0]   ctrl0;
        logic [`TMOC_DATA_W-1:0]   ctrl1;
        logic [`TMOC_CNT_W-1:0]    cmpa;
        logic [`TMOC_CNT_W-1:0]    cnt;
        logic                      en_prev;
        logic                      lvl;
        logic                      sp_act;
        logic [`TMOC_PINS-1:0]     pin;
        logic [`TMOC_PINS-1:0]     oe;
        logic                      match_a;
        logic                      match_p;
        logic [`TMOC_DATA_W-1:0]   rdata;
    } tmoc_state_s;

endpackage : tmoc_pkg

// ### rtl/tmoc_core.sv
// Output-pin, polarity, period/duty and counter-clear control of a 10-bit timer,
// with its counter, compare-A value and control registers.
// Assumes count_tick is a one-cycle pulse from the clock select logic and that
// all inputs are synchronous to ref_clk.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_cfg.svh"

// Function
// - Compare mode: compare-A match sets pin high, low or toggles per output function
// - Compare mode: output function 00 leaves the pin unchanged on a match
// - Compare mode: level control bit gives the initial pin level
// - Compare mode: enable rising edge restores the pin to its initial level
// - Requesting the initial level gives no visible change; software picks another
// - PWM and single pulse: level control bit picks the active level
// - Timer/counter mode ignores level control and polarity bits
// - Polarity bit 1 inverts the pins, 0 passes them straight
// - Swap bit 0: P sets period, A duty; 1 swaps the roles
// - Clear-select 1 clears the counter on compare-A match
// - Clear-select 0 clears the counter on compare-P match or overflow
// - Overflow clear only when compare-P is zero, else compare-P match
// - PWM, single pulse and capture modes ignore the clear-select bit
// - Counter readable as low and high bytes, not writable, resets zero
// - Unused high bits of counter and compare-A high bytes read zero
// - Compare-A readable and writable as low and high bytes, resets zero
// - Output function codes for compare mode and for PWM mode
// - Mode field: compare, capture, PWM/single pulse, timer/counter
// - Enable rising clears the counter; falling stops it holding its value
// - Compare-A uses all ten bits, compare-P only the top three
module tmoc_core
    import tmoc_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire tmoc_bus_req_s             bus_req,
    output var  logic [`TMOC_DATA_W-1:0]   rdata,
    input  wire logic                      count_tick,
    output var  logic [`TMOC_CNT_W-1:0]    counter_value,
    output var  logic                      match_a,
    output var  logic                      match_p,
    output var  logic                      counter_enable,
    output var  logic                      timer_output_pin_a_o,
    output var  logic                      timer_output_pin_a_oe,
    output var  logic                      timer_output_pin_b_o,
    output var  logic                      timer_output_pin_b_oe
);

    tmoc_state_s                st_ff;
    tmoc_state_s                nxt_st;

    // Decoded control fields
    tmoc_mode_e                 mode;
    logic [1:0]                 out_func;
    logic                       oc;
    logic                       pol;
    logic                       dpx;
    logic                       cclr;
    logic                       en;
    logic                       pause;
    logic [`TMOC_COMPARE_P_VALUE_W-1:0]    compare_p_value;
    logic                       en_rise;
    logic                       step;
    logic [`TMOC_CNT_W-1:0]     cnt_inc;
    logic                       a_hit;
    logic                       p_hit;
    logic                       clr;
    logic [`TMOC_CNT_W-1:0]     duty;
    logic                       pwm_act;
    logic                       act;
    logic                       drive;

    // Field decode of the stored control bytes
    assign mode     = tmoc_mode_e'(st_ff.ctrl1[`TMOC_C1_MODE_HI:`TMOC_C1_MODE_LO]);
    assign out_func = st_ff.ctrl1[`TMOC_C1_IO_HI:`TMOC_C1_IO_LO];
    assign oc       = st_ff.ctrl1[`TMOC_C1_OC];
    assign pol      = st_ff.ctrl1[`TMOC_C1_POL];
    assign dpx      = st_ff.ctrl1[`TMOC_C1_DPX];
    assign cclr     = st_ff.ctrl1[`TMOC_C1_CCLR];
    assign en       = st_ff.ctrl0[`TMOC_C0_EN];
    assign pause    = st_ff.ctrl0[`TMOC_C0_PAUSE];
    assign compare_p_value     = st_ff.ctrl0[`TMOC_C0_COMPARE_P_VALUE_HI:`TMOC_C0_COMPARE_P_VALUE_LO];

    // Counter step and the two comparators
    assign en_rise  = en & ~st_ff.en_prev;
    assign step     = en & ~pause & count_tick & ~en_rise;
    assign cnt_inc  = st_ff.cnt + `TMOC_CNT_ONE;
    assign a_hit    = (cnt_inc == st_ff.cmpa);
    // P looks at the top three bits only; a zero P value hits on the wrap to zero
    assign p_hit    = (cnt_inc[`TMOC_CNT_W-1:`TMOC_CNT_W-`TMOC_COMPARE_P_VALUE_W] == compare_p_value) &&
                      (cnt_inc[`TMOC_CNT_W-`TMOC_COMPARE_P_VALUE_W-1:0] == `TMOC_LOW7_ZERO);

    // Clear source; PWM picks the period comparator, capture only wraps
    always_comb begin
        case (mode)
            MODE_PWM: clr = dpx ? a_hit : p_hit;
            MODE_CAP: clr = 1'b0;
            default:  clr = cclr ? a_hit : p_hit;
        endcase
    end

    // Duty threshold and the raw PWM active phase
    assign duty    = dpx ? {compare_p_value, `TMOC_LOW7_ZERO} : st_ff.cmpa;
    assign pwm_act = (st_ff.cnt < duty);

    // Active request in PWM mode per output function
    always_comb begin
        case (out_func)
            `TMOC_IO_NONE: act = 1'b0;
            `TMOC_IO_LOW:  act = 1'b1;
            `TMOC_IO_HIGH: act = pwm_act;
            default:       act = st_ff.sp_act;
        endcase
    end

    // Pins are driven only in compare and PWM modes
    assign drive = (mode == MODE_CMP) || (mode == MODE_PWM);

    // Next state: registers, counter, output level and pins
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.match_a = 1'b0;
        nxt_st.match_p = 1'b0;
        nxt_st.rdata   = `TMOC_RST_BYTE;
        nxt_st.en_prev = en;

        // Register writes; counter bytes have no write path
        if (bus_req.wr) begin
            case (bus_req.addr)
                `TMOC_OFS_CTRL0:   nxt_st.ctrl0 = bus_req.wdata;
                `TMOC_OFS_CTRL1:   nxt_st.ctrl1 = bus_req.wdata;
                `TMOC_OFS_CMPA_LO: nxt_st.cmpa[7:0] = bus_req.wdata;
                `TMOC_OFS_CMPA_HI: nxt_st.cmpa[9:8] = bus_req.wdata[1:0];
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle; unmapped reads give zero
        if (bus_req.rd) begin
            case (bus_req.addr)
                `TMOC_OFS_CTRL0:   nxt_st.rdata = st_ff.ctrl0;
                `TMOC_OFS_CTRL1:   nxt_st.rdata = st_ff.ctrl1;
                `TMOC_OFS_CNT_LO:  nxt_st.rdata = st_ff.cnt[7:0];
                `TMOC_OFS_CNT_HI:  nxt_st.rdata = {6'h00, st_ff.cnt[9:8]};
                `TMOC_OFS_CMPA_LO: nxt_st.rdata = st_ff.cmpa[7:0];
                `TMOC_OFS_CMPA_HI: nxt_st.rdata = {6'h00, st_ff.cmpa[9:8]};
                default:           nxt_st.rdata = `TMOC_RST_BYTE;
            endcase
        end

        // Counter: enable edge clears, falling edge simply stops stepping
        if (en_rise) begin
            nxt_st.cnt    = `TMOC_RST_CNT;
            nxt_st.sp_act = 1'b1;
        end else if (step) begin
            nxt_st.cnt     = clr ? `TMOC_RST_CNT : cnt_inc;
            nxt_st.match_a = a_hit;
            nxt_st.match_p = p_hit;
            if (mode == MODE_PWM && clr) begin
                nxt_st.sp_act = 1'b0;           // Single pulse ends at the period
            end
        end

        // Output level before polarity
        case (mode)
            MODE_CMP: begin
                if (en_rise) begin
                    nxt_st.lvl = oc;
                end else if (step && a_hit) begin
                    case (out_func)
                        `TMOC_IO_LOW:    nxt_st.lvl = 1'b0;
                        `TMOC_IO_HIGH:   nxt_st.lvl = 1'b1;
                        `TMOC_IO_TOGGLE: nxt_st.lvl = ~st_ff.lvl;
                        default:         nxt_st.lvl = st_ff.lvl;
                    endcase
                end
            end
            // Level control picks the active sense; output function is set while off
            MODE_PWM: nxt_st.lvl = act ? oc : ~oc;
            default:  nxt_st.lvl = st_ff.lvl;
        endcase

        // Both pins carry the same waveform; one registered stage before the pad
        for (int i = 0; i < `TMOC_PINS; i++) begin
            nxt_st.oe[i]  = drive;
            nxt_st.pin[i] = drive & (nxt_st.lvl ^ pol);
        end
    end

    // State register; synchronous reset clears everything
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign rdata                 = st_ff.rdata;
    assign counter_value         = st_ff.cnt;
    assign match_a               = st_ff.match_a;
    assign match_p               = st_ff.match_p;
    assign counter_enable        = en;
    assign timer_output_pin_a_o  = st_ff.pin[0];
    assign timer_output_pin_a_oe = st_ff.oe[0];
    assign timer_output_pin_b_o  = st_ff.pin[1];
    assign timer_output_pin_b_oe = st_ff.oe[1];

    // Checks on the logic above
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_cnt_lo_read;
        bus_req.rd && bus_req.addr == `TMOC_OFS_CNT_LO |=> rdata == $past(st_ff.cnt[7:0]);
    endproperty
    a_cnt_lo_read: assert property (p_cnt_lo_read)
        else $error("counter low byte read mismatch");

    property p_cnt_hi_zero;
        bus_req.rd && bus_req.addr == `TMOC_OFS_CNT_HI |=> rdata[7:2] == 6'h00 &&
            rdata[1:0] == $past(st_ff.cnt[9:8]);
    endproperty
    a_cnt_hi_zero: assert property (p_cnt_hi_zero)
        else $error("counter high byte read mismatch");

    property p_cmpa_lo_write;
        bus_req.wr && bus_req.addr == `TMOC_OFS_CMPA_LO |=> st_ff.cmpa[7:0] == $past(bus_req.wdata);
    endproperty
    a_cmpa_lo_write: assert property (p_cmpa_lo_write)
        else $error("compare-A low byte not written");

    property p_cmpa_hi_read;
        bus_req.wr && bus_req.addr == `TMOC_OFS_CMPA_HI ##1 bus_req.rd &&
            bus_req.addr == `TMOC_OFS_CMPA_HI |=> rdata == {6'h00, $past(bus_req.wdata[1:0], 2)};
    endproperty
    a_cmpa_hi_read: assert property (p_cmpa_hi_read)
        else $error("compare-A high byte readback wrong");

    property p_en_clear;
        en_rise |=> counter_value == `TMOC_RST_CNT;
    endproperty
    a_en_clear: assert property (p_en_clear)
        else $error("counter not cleared on enable");

    property p_init_level;
        en_rise && mode == MODE_CMP && !bus_req.wr |=>
            timer_output_pin_a_o == ($past(oc) ^ $past(pol));
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("pin not restored to initial level");

    property p_set_high;
        mode == MODE_CMP && step && a_hit && out_func == `TMOC_IO_HIGH |=> st_ff.lvl;
    endproperty
    a_set_high: assert property (p_set_high)
        else $error("compare match did not set level high");

    property p_no_change;
        mode == MODE_CMP && !en_rise && out_func == `TMOC_IO_NONE |=> $stable(st_ff.lvl);
    endproperty
    a_no_change: assert property (p_no_change)
        else $error("level changed with output function none");

    property p_timer_quiet;
        mode == MODE_TMR && !bus_req.wr |=> !timer_output_pin_a_oe && !timer_output_pin_b_o;
    endproperty
    a_timer_quiet: assert property (p_timer_quiet)
        else $error("pins driven in timer mode");

    property p_clear_a;
        mode == MODE_CMP && cclr && step && a_hit |=> counter_value == `TMOC_RST_CNT && match_a;
    endproperty
    a_clear_a: assert property (p_clear_a)
        else $error("counter not cleared on compare-A");

    property p_set_low;
        mode == MODE_CMP && step && a_hit && out_func == `TMOC_IO_LOW |=> !st_ff.lvl;
    endproperty
    a_set_low: assert property (p_set_low)
        else $error("compare match did not set level low");

    property p_toggle;
        mode == MODE_CMP && step && a_hit && out_func == `TMOC_IO_TOGGLE |=>
            st_ff.lvl != $past(st_ff.lvl);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("compare match did not toggle level");

    // Enable rise reloads the initial level even when a match lands that cycle
    property p_init_load;
        en_rise && mode == MODE_CMP |=> st_ff.lvl == $past(oc);
    endproperty
    a_init_load: assert property (p_init_load)
        else $error("initial level not loaded on enable");

    property p_pin_follow;
        drive |=> timer_output_pin_a_o == (st_ff.lvl ^ $past(pol)) &&
            timer_output_pin_b_o == timer_output_pin_a_o;
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("pin does not follow level and polarity");

    property p_pwm_active;
        mode == MODE_PWM && out_func == `TMOC_IO_LOW |=> st_ff.lvl == $past(oc);
    endproperty
    a_pwm_active: assert property (p_pwm_active)
        else $error("PWM active state not at the active level");

    property p_pwm_idle;
        mode == MODE_PWM && out_func == `TMOC_IO_NONE |=> st_ff.lvl == !$past(oc);
    endproperty
    a_pwm_idle: assert property (p_pwm_idle)
        else $error("PWM inactive state not at the idle level");

    property p_pwm_duty;
        mode == MODE_PWM && out_func == `TMOC_IO_HIGH && !dpx |=> st_ff.lvl ==
            (($past(st_ff.cnt) < $past(st_ff.cmpa)) ? $past(oc) : !$past(oc));
    endproperty
    a_pwm_duty: assert property (p_pwm_duty)
        else $error("PWM duty not set by compare-A");

    property p_pwm_period;
        mode == MODE_PWM && !dpx && step && p_hit |=> counter_value == `TMOC_RST_CNT;
    endproperty
    a_pwm_period: assert property (p_pwm_period)
        else $error("PWM period not set by compare-P");

    property p_pwm_swap;
        mode == MODE_PWM && dpx && step && a_hit |=> counter_value == `TMOC_RST_CNT;
    endproperty
    a_pwm_swap: assert property (p_pwm_swap)
        else $error("swapped PWM period not set by compare-A");

    // Clear-select high must not let compare-A end a PWM period
    property p_pwm_no_cclr;
        mode == MODE_PWM && !dpx && cclr && step && !p_hit |=>
            counter_value == $past(cnt_inc);
    endproperty
    a_pwm_no_cclr: assert property (p_pwm_no_cclr)
        else $error("PWM counter cleared by clear-select");

    property p_cap_wrap;
        mode == MODE_CAP && step |=> counter_value == $past(cnt_inc);
    endproperty
    a_cap_wrap: assert property (p_cap_wrap)
        else $error("capture counter cleared by a comparator");

    property p_clear_p;
        mode == MODE_CMP && !cclr && step && p_hit |=>
            counter_value == `TMOC_RST_CNT && match_p;
    endproperty
    a_clear_p: assert property (p_clear_p)
        else $error("counter not cleared on compare-P");

    property p_a_not_clear;
        mode == MODE_CMP && !cclr && step && !p_hit |=> counter_value == $past(cnt_inc);
    endproperty
    a_a_not_clear: assert property (p_a_not_clear)
        else $error("counter cleared without compare-P match");

    // A zero compare-P value leaves only the wrap after the top count
    property p_overflow;
        mode == MODE_CMP && !cclr && compare_p_value == 3'h0 && step && &st_ff.cnt |=>
            counter_value == `TMOC_RST_CNT && match_p;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("counter did not clear on overflow");

    property p_match_p_edge;
        match_p |-> counter_value[6:0] == `TMOC_LOW7_ZERO;
    endproperty
    a_match_p_edge: assert property (p_match_p_edge)
        else $error("compare-P match off a 128-count boundary");

    property p_cmpa_hi_write;
        bus_req.wr && bus_req.addr == `TMOC_OFS_CMPA_HI |=>
            st_ff.cmpa[9:8] == $past(bus_req.wdata[1:0]);
    endproperty
    a_cmpa_hi_write: assert property (p_cmpa_hi_write)
        else $error("compare-A high byte not written");

    property p_hold_off;
        !en |=> $stable(counter_value);
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("counter moved while switched off");

endmodule : tmoc_core

`default_nettype wire

// ### tb/tmoc_pin_sink.sv
// Far-side model: the board pads behind the two timer output pins.
// Assumes each pad carries a pull-down, so a released pin reads low.
`timescale 1ns/1ps
`default_nettype none
module tmoc_pin_sink (
    input  wire logic pin_a_o,
    input  wire logic pin_a_oe,
    input  wire logic pin_b_o,
    input  wire logic pin_b_oe,
    output wire logic pad_a,
    output wire logic pad_b
);
    // Pull-down wins whenever the timer lets go of a pin
    assign pad_a = pin_a_oe ? pin_a_o : 1'b0;
    assign pad_b = pin_b_oe ? pin_b_o : 1'b0;
endmodule : tmoc_pin_sink
`default_nettype wire

// ### tb/tmoc_core_test.sv
// Self-checking bench for tmoc_core: register bus tasks, counter and pin model.
// Assumes a 100 MHz ref_clk, ticks driven by the bench, map of tmoc_cfg.svh.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tmoc_core_test
    import tmoc_pkg::*;
;
    logic          ref_clk, rst_n, count_tick, match_a, match_p, counter_enable;
    logic          pa_o, pa_oe, pb_o, pb_oe, oc, pol;
    wire logic     pad_a, pad_b;
    tmoc_bus_req_s bus_req;
    logic [7:0]    rdata;
    logic [9:0]    counter_value, a_v;
    logic [1:0]    io;
    int            n_fail = 0, n_tests = 0, n_ma = 0, n_mp = 0, seed, cnt_m, tot, ma0;

    tmoc_core u_tmoc_core (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
        .rdata(rdata), .count_tick(count_tick), .counter_value(counter_value),
        .match_a(match_a), .match_p(match_p), .counter_enable(counter_enable),
        .timer_output_pin_a_o(pa_o), .timer_output_pin_a_oe(pa_oe),
        .timer_output_pin_b_o(pb_o), .timer_output_pin_b_oe(pb_oe));
    tmoc_pin_sink u_tmoc_pin_sink (.pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o),
        .pin_b_oe(pb_oe), .pad_a(pad_a), .pad_b(pad_b));

    // Clock and match pulse counters
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (match_a === 1'b1) n_ma++;
        if (match_p === 1'b1) n_mp++;
    end

    task automatic end_of_test;
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        `CHK(nm, e, rdata)
    endtask : rd

    task automatic rd_cnt;
        rd(3'h2, 8'(cnt_m), "counter_value_low");
        rd(3'h3, {6'h00, 2'(cnt_m >> 8)}, "counter_value_high");
        `CHK("counter_value", 10'(cnt_m), counter_value)
    endtask : rd_cnt

    // Model counter wraps at the period the bench expects; pins lag two cycles
    task automatic tick(input int n, input int per);
        repeat (n) begin
            @(posedge ref_clk);
            count_tick <= 1'b1;
        end
        @(posedge ref_clk);
        count_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
        cnt_m = (cnt_m + n) % per;
        tot += n;
    endtask : tick

    // Timer off before touching the output function, then enable rise
    task automatic cfg(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a);
        wr(3'h0, 8'h00);
        wr(3'h1, c1);
        wr(3'h4, a[7:0]);
        wr(3'h5, {6'h3f, a[9:8]});
        wr(3'h0, {5'h01, p});
        repeat (4) @(posedge ref_clk);
        cnt_m = 0;
        tot = 0;
        ma0 = n_ma;
        `CHK("counter_enable", 1'b1, counter_enable)
    endtask : cfg

    // PWM step: pad follows active level while active, inverted by polarity
    task automatic pw(input int n, input int per, input int duty);
        logic act;
        tick(n, per);
        act = (io == 2'h1) || (io == 2'h2 && cnt_m < duty) || (io == 2'h3 && tot < per);
        `CHK("pwm_pad", (act ? oc : ~oc) ^ pol, pad_a)
        rd_cnt;
    endtask : pw

    initial begin
        seed = 32'h54b4;
        rst_n = 1'b0;
        count_tick = 1'b0;
        bus_req = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(3'(i), 8'h00, "reset_read");
        a_v = 10'($random(seed));
        wr(3'h4, a_v[7:0]);
        wr(3'h5, 8'hff);
        wr(3'h2, 8'h55);
        wr(3'h3, 8'hff);
        rd(3'h4, a_v[7:0], "compare_a_low");
        rd(3'h5, 8'h03, "compare_a_high");
        rd(3'h2, 8'h00, "counter_value_low");
        // Compare mode: every output function with both initial levels
        for (int k = 0; k < 8; k++) begin
            oc = k[0];
            io = 2'(k >> 1);
            pol = 1'($random(seed));
            a_v = 10'h003 + 10'($unsigned($random(seed)) % 40);
            cfg({2'h0, io, oc, pol, 2'h1}, 3'h0, a_v);
            `CHK("initial_pad", oc ^ pol, pad_a)
            tick(a_v - 1, a_v);
            rd_cnt;
            tick(1, a_v);
            `CHK("match_a_count", ma0 + 1, n_ma)
            `CHK("match_pad", ((io == 2'h0) ? oc : (io == 2'h3) ? ~oc : io[1]) ^ pol, pad_a)
            `CHK("pad_b", pad_a, pad_b)
            rd_cnt;
        end
        // Timer mode drops the pins whatever level and polarity say
        cfg(8'hfd, 3'h0, 10'h005);
        tick(7, 5);
        `CHK("timer_oe", 1'b0, pa_oe)
        `CHK("timer_oe_b", 1'b0, pb_oe)
        rd_cnt;
        // Capture mode only wraps: neither comparator clears, pins released
        cfg(8'h41, 3'h1, 10'h005);
        tick(7, 1024);
        `CHK("capture_oe", 1'b0, pa_oe)
        rd_cnt;
        // Clear-select 0: compare-P boundary, then overflow when P is zero
        cfg(8'h00, 3'h1, 10'h00a);
        tick(130, 128);
        rd_cnt;
        `CHK("match_p_count", 1, n_mp)
        cfg(8'h00, 3'h0, 10'h00a);
        tick(1030, 1024);
        rd_cnt;
        `CHK("match_p_count", 2, n_mp)
        // PWM with swap 0: period 128 from P, duty 40 from A, clear-select ignored
        for (int k = 0; k < 4; k++) begin
            io = 2'(k);
            oc = 1'($random(seed));
            pol = 1'($random(seed));
            cfg({2'h2, io, oc, pol, 2'h1}, 3'h1, 10'h028);
            pw(10, 128, 40);
            pw(50, 128, 40);
            pw(100, 128, 40);
        end
        // Swap 1: period from A, duty 128 from P
        io = 2'h2;
        cfg({2'h2, io, oc, pol, 2'h2}, 3'h1, 10'h0c8);
        pw(100, 200, 128);
        pw(50, 200, 128);
        pw(60, 200, 128);
        end_of_test;
    end

    // Hang guard
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        end_of_test;
    end
endmodule : tmoc_core_test
`default_nettype wire
